// ===== rtl/sst_pkg.sv
// constants and register map of the per-axis safe stop block
// assumes a single 40 MHz clock and a simple strobe register port
package sst_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned DISC_TIME_MS    = 100;
  localparam int unsigned DISC_CYCLES     = CLK_HZ / 1000 * DISC_TIME_MS;
  localparam int unsigned STOP_DELAY_MS   = 2;
  localparam int unsigned STOP_DELAY_CYC  = CLK_HZ / 1000 * STOP_DELAY_MS;
  localparam int unsigned N_INST          = 3;
  localparam int unsigned N_SEL           = 8;

  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_INST_CFG = 4'h1;
  localparam logic [3:0] ADDR_SEL      = 4'h2;
  localparam logic [3:0] ADDR_DELAY    = 4'h3;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;

  // ctrl fields
  localparam int unsigned CTRL_TO_READY  = 0;
  localparam int unsigned CTRL_TO_FB     = 1;
  localparam int unsigned CTRL_FB_EN     = 2;
  localparam int unsigned CTRL_REPORT    = 3;
  localparam int unsigned CTRL_EXTENDED  = 4;
  localparam int unsigned CTRL_VEL_MON   = 5;
  localparam int unsigned CTRL_DUAL      = 6;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0041;
  // inst_cfg: bit i used, bits 8+4*i.. safe input selection of instance i
  localparam logic [31:0] INST_CFG_RESET = 32'h0000_0001;
  localparam logic [3:0]  SEL_AXIS1      = 4'h5;
  localparam logic [3:0]  SEL_AXIS2      = 4'h6;
  localparam logic [3:0]  SEL_NONE       = 4'h0;

  // irq / status bits
  localparam int unsigned EV_IO_FAIL = 0;
  localparam int unsigned EV_TO      = 1;
  localparam int unsigned EV_STOP    = 2;
  localparam int unsigned EV_W       = 3;

  typedef enum logic [1:0] {SST_IDLE, SST_RAMP, SST_DONE} sst_stop_st_t;

  // selection 1..4 single inputs, 5 and 6 dual pairs
  function automatic logic sst_sel_level(input logic [3:0] sel,
                                         input logic [3:0] sin);
    case (sel)
      4'h1:    sst_sel_level = ~sin[0];
      4'h2:    sst_sel_level = ~sin[1];
      4'h3:    sst_sel_level = ~sin[2];
      4'h4:    sst_sel_level = ~sin[3];
      4'h5:    sst_sel_level = ~sin[0] | ~sin[1];
      4'h6:    sst_sel_level = ~sin[2] | ~sin[3];
      default: sst_sel_level = 1'b0;
    endcase
  endfunction : sst_sel_level
endpackage : sst_pkg

// ===== rtl/sst_disc_mon.sv
// dual-channel discrepancy monitor for one safe input pair
// assumes inputs already synchronous to ref_clk
module sst_disc_mon #(
  parameter int unsigned LIMIT = sst_pkg::DISC_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic enable,
  input  wire logic in_a,
  input  wire logic in_b,
  output logic      fail
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        fail;
  } sst_disc_t;
  sst_disc_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (!enable || in_a == in_b) begin
      st_next.cnt = 32'h0;
    end else if (st_reg.cnt < LIMIT) begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end else begin
      st_next.fail = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  // failure latches until reset; a safety fault is not self-clearing
  assign fail = st_reg.fail;
endmodule : sst_disc_mon

// ===== rtl/sst_stop_inst.sv
// one timed stop instance: ramp request then torque off after the delay
// assumes start is a level request from the combined sources
module sst_stop_inst (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire logic        clear,
  input  wire logic [31:0] delay,
  output logic             active,
  output logic             done
);
  typedef struct packed {
    sst_pkg::sst_stop_st_t fsm;
    logic [31:0]           cnt;
  } sst_inst_t;
  sst_inst_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    case (st_reg.fsm)
      sst_pkg::SST_IDLE: begin
        if (start) begin
          st_next.fsm = sst_pkg::SST_RAMP;
          st_next.cnt = 32'h0;
        end
      end
      sst_pkg::SST_RAMP: begin
        if (st_reg.cnt + 32'h1 >= delay) begin
          st_next.fsm = sst_pkg::SST_DONE;
        end else begin
          st_next.cnt = st_reg.cnt + 32'h1;
        end
      end
      sst_pkg::SST_DONE: begin
        if (clear && !start) begin
          st_next.fsm = sst_pkg::SST_IDLE;
        end
      end
      default: st_next.fsm = sst_pkg::SST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign active = (st_reg.fsm != sst_pkg::SST_IDLE);
  assign done   = (st_reg.fsm == sst_pkg::SST_DONE);
endmodule : sst_stop_inst

// ===== rtl/sst_axis.sv
// per-axis safe stop top: input monitor, three timed stops, torque off
// assumes safe inputs are active low (low requests stop) and synchronous
//
// Our own choices: the plain strobed port and the register offsets.
module sst_axis #(
  parameter int unsigned AXIS_ID    = 1,
  parameter int unsigned DISC_LIMIT = sst_pkg::DISC_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic [3:0]  safe_in,
  input  wire logic [2:0]  fb_stop_req,
  input  wire logic        fb_to_req,
  input  wire logic [2:0]  fault_stop_req,
  input  wire logic        fault_to_req,
  input  wire logic        axis_enabled,
  input  wire logic        restart_ack,
  output logic [2:0]       stop_active,
  output logic [2:0]       ramp_request,
  output logic             torque_off_active,
  output logic             stage_enable,
  output logic             io_fail_warning,
  output logic             io_fail_fault,
  output logic             irq
);
  localparam logic [3:0] SEL_DEF =
      (AXIS_ID == 2) ? sst_pkg::SEL_AXIS2 : sst_pkg::SEL_AXIS1;

  typedef struct packed {
    logic [31:0]         ctrl;
    logic [31:0]         inst_cfg;
    logic [3:0]          to_sel;
    logic [31:0]         delay;
    logic [sst_pkg::EV_W-1:0] irq_stat;
    logic [sst_pkg::EV_W-1:0] irq_mask;
    logic [31:0]         rdata;
    logic                to_latch;
    logic [2:0]          stop_active;
    logic [2:0]          ramp;
    logic                to_active;
    logic                stage_en;
    logic                warn;
    logic                fault;
    logic                irq;
    logic                prev_to;
    logic                prev_fail;
    logic [2:0]          prev_stop;
  } sst_axis_st_t;
  sst_axis_st_t st_reg, st_next;

  logic       io_fail;
  logic [2:0] inst_start;
  logic [2:0] inst_active;
  logic [2:0] inst_done;
  logic       stop_allowed;
  logic       to_req;
  logic       to_hold;

  sst_disc_mon #(
    .LIMIT (DISC_LIMIT)
  ) u_disc (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .enable  (st_reg.ctrl[sst_pkg::CTRL_DUAL]),
    .in_a    (safe_in[0]),
    .in_b    (safe_in[1]),
    .fail    (io_fail)
  );

  assign stop_allowed = !st_reg.ctrl[sst_pkg::CTRL_EXTENDED] ||
                        !st_reg.ctrl[sst_pkg::CTRL_VEL_MON];

  genvar gi;
  generate
    for (gi = 0; gi < sst_pkg::N_INST; gi++) begin : g_inst
      logic fb_ok;
      logic sel_req;
      assign fb_ok = st_reg.ctrl[sst_pkg::CTRL_FB_EN] &&
                     st_reg.inst_cfg[gi] && fb_stop_req[gi];
      assign sel_req = st_reg.inst_cfg[gi] && sst_pkg::sst_sel_level(
                       st_reg.inst_cfg[8+4*gi +: 4], safe_in);
      assign inst_start[gi] = stop_allowed && (fb_ok || sel_req ||
                              (st_reg.inst_cfg[gi] && fault_stop_req[gi]) ||
                              ((gi == 0) && io_fail));
      sst_stop_inst u_stop (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .start   (inst_start[gi]),
        .clear   (restart_ack),
        .delay   (st_reg.delay),
        .active  (inst_active[gi]),
        .done    (inst_done[gi])
      );
    end
  endgenerate

  assign to_req = st_reg.ctrl[sst_pkg::CTRL_TO_READY] && (
      (|inst_done) || fault_to_req ||
      (st_reg.ctrl[sst_pkg::CTRL_TO_FB] &&
       st_reg.ctrl[sst_pkg::CTRL_FB_EN] && fb_to_req) ||
      sst_pkg::sst_sel_level(st_reg.to_sel, safe_in));

  // a finished stop that the ack retires must not re-latch torque off,
  // so only sources that outlive the ack keep it on
  assign to_hold = st_reg.ctrl[sst_pkg::CTRL_TO_READY] && (
      (|(inst_done & inst_start)) || fault_to_req ||
      (st_reg.ctrl[sst_pkg::CTRL_TO_FB] &&
       st_reg.ctrl[sst_pkg::CTRL_FB_EN] && fb_to_req) ||
      sst_pkg::sst_sel_level(st_reg.to_sel, safe_in));

  always_comb begin
    logic [sst_pkg::EV_W-1:0] ev;
    ev = '0;
    st_next = st_reg;
    st_next.rdata = 32'h0;
    if (reg_wr) begin
      case (reg_addr)
        sst_pkg::ADDR_CTRL:     st_next.ctrl     = reg_wdata;
        sst_pkg::ADDR_INST_CFG: st_next.inst_cfg = reg_wdata;
        sst_pkg::ADDR_SEL:      st_next.to_sel   = reg_wdata[3:0];
        sst_pkg::ADDR_DELAY:    st_next.delay    = reg_wdata;
        sst_pkg::ADDR_IRQ_MASK:
          st_next.irq_mask = reg_wdata[sst_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        sst_pkg::ADDR_CTRL:     st_next.rdata = st_reg.ctrl;
        sst_pkg::ADDR_INST_CFG: st_next.rdata = st_reg.inst_cfg;
        sst_pkg::ADDR_SEL:      st_next.rdata = {28'h0, st_reg.to_sel};
        sst_pkg::ADDR_DELAY:    st_next.rdata = st_reg.delay;
        sst_pkg::ADDR_STATUS:
          st_next.rdata = {24'h0, st_reg.fault, st_reg.warn, io_fail,
                           st_reg.to_active, 1'b0, st_reg.stop_active};
        sst_pkg::ADDR_IRQ_STAT:
          st_next.rdata = {29'h0, st_reg.irq_stat};
        sst_pkg::ADDR_IRQ_MASK:
          st_next.rdata = {29'h0, st_reg.irq_mask};
        default:                st_next.rdata = 32'h0;
      endcase
    end
    // torque off holds until acknowledged with the request gone
    if (restart_ack && !to_hold) begin
      st_next.to_latch = 1'b0;
    end else if (to_req) begin
      st_next.to_latch = 1'b1;
    end
    st_next.stop_active = inst_active;
    st_next.ramp        = inst_active & ~inst_done;
    st_next.to_active   = st_next.to_latch;
    st_next.stage_en    = !st_next.to_latch;
    st_next.warn  = io_fail && !axis_enabled;
    st_next.fault = io_fail && axis_enabled &&
                    st_reg.ctrl[sst_pkg::CTRL_REPORT];
    st_next.prev_to   = st_next.to_latch;
    st_next.prev_fail = io_fail;
    st_next.prev_stop = inst_active;
    ev[sst_pkg::EV_IO_FAIL] = io_fail && !st_reg.prev_fail;
    ev[sst_pkg::EV_TO]      = st_next.to_latch && !st_reg.prev_to;
    ev[sst_pkg::EV_STOP]    = |(inst_active & ~st_reg.prev_stop);
    // set wins over the read clear
    if (reg_rd && reg_addr == sst_pkg::ADDR_IRQ_STAT) begin
      st_next.irq_stat = ev;
    end else begin
      st_next.irq_stat = st_reg.irq_stat | ev;
    end
    st_next.irq = |(st_next.irq_stat & st_reg.irq_mask);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg          <= '0;
      st_reg.ctrl     <= sst_pkg::CTRL_RESET;
      st_reg.inst_cfg <= sst_pkg::INST_CFG_RESET;
      st_reg.to_sel   <= SEL_DEF;
      st_reg.delay    <= sst_pkg::STOP_DELAY_CYC;
      st_reg.stage_en <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata         = st_reg.rdata;
  assign stop_active       = st_reg.stop_active;
  assign ramp_request      = st_reg.ramp;
  assign torque_off_active = st_reg.to_active;
  assign stage_enable      = st_reg.stage_en;
  assign io_fail_warning   = st_reg.warn;
  assign io_fail_fault     = st_reg.fault;
  assign irq               = st_reg.irq;
endmodule : sst_axis

// ===== dv/sst_axis_sva.sv
// port-level checker for the per-axis safe stop block
// assumes it is bound onto sst_axis and sees only that module's ports
module sst_axis_sva (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0]  safe_in,
  input wire logic        fb_to_req,
  input wire logic        fault_to_req,
  input wire logic        restart_ack,
  input wire logic [2:0]  stop_active,
  input wire logic [2:0]  ramp_request,
  input wire logic        torque_off_active,
  input wire logic        stage_enable,
  input wire logic        io_fail_warning,
  input wire logic        io_fail_fault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic any_src;
  assign any_src = fb_to_req | fault_to_req | (safe_in != 4'hf)
                   | (|stop_active);
  sequence ramp_end_s;
    $fell(ramp_request[0]) && stop_active[0];
  endsequence
  sequence off_soon_s;
    ##[0:4] torque_off_active;
  endsequence
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  stage_off_a: assert property (
    torque_off_active |-> !stage_enable)
    else $error("output stage on during torque off");
  ramp_in_stop_a: assert property (
    (ramp_request & ~stop_active) == 3'h0)
    else $error("ramp request without active stop");
  stop_hold_a: assert property (
    stop_active[0] && !restart_ack && !$past(restart_ack)
    |=> stop_active[0])
    else $error("timed stop ended early");
  torque_hold_a: assert property (
    torque_off_active && !restart_ack && !$past(restart_ack)
    |=> torque_off_active)
    else $error("torque off released without ack");
  fail_excl_a: assert property (
    !(io_fail_warning && io_fail_fault))
    else $error("warning and fault at once");
  ramp_to_off_a: assert property (
    ramp_end_s |-> off_soon_s)
    else $error("no torque off after ramp");
  torque_cause_a: assert property (
    $rose(torque_off_active)
    |-> $past(any_src) || $past(any_src, 2) || $past(any_src, 3))
    else $error("torque off without a source");
endmodule : sst_axis_sva

// ===== dv/sst_fb_model.sv
// safety controller model on the fieldbus side of the block
// assumes bench commands; each frame update lands one clock later
module sst_fb_model (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] stop_cmd,
  input  wire logic       to_cmd,
  output logic [2:0]      fb_stop_req,
  output logic            fb_to_req
);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_stop_req <= 3'h0;
      fb_to_req   <= 1'h0;
    end else begin
      fb_stop_req <= stop_cmd;
      fb_to_req   <= to_cmd;
    end
  end
endmodule : sst_fb_model

// ===== dv/safe_stop_torque_off_logic_tb.sv
// self-checking bench for sst_axis with the fieldbus controller model
// assumes a 40 MHz clock and a short discrepancy limit of 20 cycles
bind sst_axis sst_axis_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .safe_in(safe_in),
  .fb_to_req(fb_to_req), .fault_to_req(fault_to_req),
  .restart_ack(restart_ack), .stop_active(stop_active),
  .ramp_request(ramp_request), .torque_off_active(torque_off_active),
  .stage_enable(stage_enable), .io_fail_warning(io_fail_warning),
  .io_fail_fault(io_fail_fault));
module safe_stop_torque_off_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [3:0] a; logic [31:0] d;} sst_row_t;
  localparam sst_row_t ROWS [8] = '{
    '{4'h0, sst_pkg::CTRL_RESET}, '{4'h1, sst_pkg::INST_CFG_RESET},
    '{4'h2, {28'h0, sst_pkg::SEL_AXIS1}},
    '{4'h3, sst_pkg::STOP_DELAY_CYC}, '{4'h4, 32'h0},
    '{4'h5, 32'h0}, '{4'h6, 32'h0}, '{4'hf, 32'h0}};
  logic        ref_clk, arst_n, reg_wr, reg_rd, fb_to_req, to_cmd;
  logic        fault_to_req, axis_enabled, restart_ack, irq;
  logic        torque_off_active, stage_enable;
  logic        io_fail_warning, io_fail_fault;
  logic [3:0]  reg_addr, safe_in;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [2:0]  fb_stop_req, stop_cmd, fault_stop_req;
  logic [2:0]  stop_active, ramp_request;
  int          num_errors, samples_checked, cycles;
  sst_fb_model u_fb (.ref_clk(ref_clk), .arst_n(arst_n),
    .stop_cmd(stop_cmd), .to_cmd(to_cmd), .fb_stop_req(fb_stop_req),
    .fb_to_req(fb_to_req));
  sst_axis #(.AXIS_ID(1), .DISC_LIMIT(20)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .safe_in(safe_in), .fb_stop_req(fb_stop_req), .fb_to_req(fb_to_req),
    .fault_stop_req(fault_stop_req), .fault_to_req(fault_to_req),
    .axis_enabled(axis_enabled), .restart_ack(restart_ack),
    .stop_active(stop_active), .ramp_request(ramp_request),
    .torque_off_active(torque_off_active), .stage_enable(stage_enable),
    .io_fail_warning(io_fail_warning), .io_fail_fault(io_fail_fault),
    .irq(irq));
  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : rd
  // bounded wait for torque off to come on
  task automatic wait_to();
    for (int i = 0; i < 40 && torque_off_active !== 1'h1; i++)
      cyc(1);
  endtask : wait_to
  task automatic ack();
    @(posedge ref_clk);
    restart_ack <= 1'h1;
    @(posedge ref_clk);
    restart_ack <= 1'h0;
    cyc(3);
  endtask : ack
  task automatic disc(input int n);
    @(posedge ref_clk);
    safe_in <= 4'he;
    repeat (n - 1) @(posedge ref_clk);
  endtask : disc
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    {arst_n, reg_wr, reg_rd, to_cmd, fault_to_req} = 5'h0;
    {axis_enabled, restart_ack, reg_addr, reg_wdata} = 38'h0;
    {stop_cmd, fault_stop_req} = 6'h0;
    safe_in = 4'hf;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'h1;
    cyc(2);
    chk("stage_enable", 1, stage_enable);
    foreach (ROWS[i]) begin
      rd(ROWS[i].a);
      chk("reg_rdata", ROWS[i].d, d);
    end
    wr(sst_pkg::ADDR_DELAY, 32'ha);
    wr(sst_pkg::ADDR_IRQ_MASK, 32'h7);
    wr(sst_pkg::ADDR_CTRL, 32'h45);
    @(posedge ref_clk) stop_cmd <= 3'h1;
    @(posedge ref_clk) stop_cmd <= 3'h0;
    cyc(3);
    chk("stop_active", 3'h1, stop_active);
    chk("ramp_request", 3'h1, ramp_request);
    wait_to();
    chk("torque_off_active", 1, torque_off_active);
    chk("stage_enable", 0, stage_enable);
    chk("irq", 1, irq);
    rd(sst_pkg::ADDR_IRQ_STAT);
    chk("irq_stat", 32'h6, d);
    cyc(2);
    chk("irq", 0, irq);
    ack();
    chk("torque_off_active", 0, torque_off_active);
    @(posedge ref_clk) stop_cmd <= 3'h2;
    cyc(6);
    chk("stop_active", 3'h0, stop_active);
    wr(sst_pkg::ADDR_INST_CFG, 32'h3);
    cyc(3);
    chk("stop_active", 3'h2, stop_active);
    @(posedge ref_clk) stop_cmd <= 3'h0;
    wait_to();
    ack();
    wr(sst_pkg::ADDR_CTRL, 32'h75);
    @(posedge ref_clk) stop_cmd <= 3'h1;
    cyc(6);
    chk("stop_active", 3'h0, stop_active);
    @(posedge ref_clk) stop_cmd <= 3'h0;
    wr(sst_pkg::ADDR_CTRL, 32'h47);
    wr(sst_pkg::ADDR_INST_CFG, 32'h303);
    @(posedge ref_clk) safe_in <= 4'hb;
    cyc(4);
    chk("stop_active", 3'h1, stop_active);
    @(posedge ref_clk) safe_in <= 4'hf;
    wait_to();
    ack();
    @(posedge ref_clk) fault_stop_req <= 3'h5;
    cyc(4);
    chk("stop_active", 3'h1, stop_active);
    @(posedge ref_clk) fault_stop_req <= 3'h0;
    wait_to();
    ack();
    @(posedge ref_clk) to_cmd <= 1'h1;
    cyc(4);
    chk("torque_off_active", 1, torque_off_active);
    @(posedge ref_clk) to_cmd <= 1'h0;
    ack();
    chk("torque_off_active", 0, torque_off_active);
    wr(sst_pkg::ADDR_CTRL, 32'h45);
    wr(sst_pkg::ADDR_SEL, {28'h0, sst_pkg::SEL_AXIS1});
    disc(15);
    @(posedge ref_clk) safe_in <= 4'hc;
    disc(15);
    @(posedge ref_clk) safe_in <= 4'hf;
    cyc(3);
    chk("io_fail_warning", 0, io_fail_warning);
    ack();
    disc(30);
    cyc(1);
    chk("io_fail_warning", 1, io_fail_warning);
    chk("io_fail_fault", 0, io_fail_fault);
    chk("stop_active", 3'h1, stop_active);
    wr(sst_pkg::ADDR_CTRL, 32'h4d);
    axis_enabled <= 1'h1;
    cyc(3);
    chk("io_fail_fault", 1, io_fail_fault);
    @(posedge ref_clk);
    arst_n  <= 1'h0;
    safe_in <= 4'hf;
    cyc(1);
    chk("torque_off_active", 0, torque_off_active);
    chk("io_fail_fault", 0, io_fail_fault);
    @(posedge ref_clk) arst_n <= 1'h1;
    cyc(3);
    chk("stage_enable", 1, stage_enable);
    complete_run();
  end
endmodule : safe_stop_torque_off_logic_tb
